/* sdram_cmd_pkg.sv */
// Shared constants, command encodings and carrier types for the SDRAM command interface
package sdram_cmd_pkg;
	localparam int BANK_BITS = 2;
	localparam int ROW_BITS = 12;
	localparam int COL_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int NUM_BANKS = 4;
	localparam int AP_BIT_POS = 10;
	localparam int MASK_LATENCY = 2;
	localparam logic [2:0] BURST_LEN_RESET = 3'h0;
	localparam logic [7:0] BURST_CNT_RESET = 8'h00;
	localparam logic [11:0] MODE_RESET = 12'h000;
	localparam logic [11:0] EXT_MODE_RESET = 12'h000;
	localparam int PART_REF_LSB = 0;
	localparam int PART_REF_BITS = 3;
	localparam int TEMP_REF_LSB = 3;
	localparam int BL_LSB = 0;
	localparam int PRECHARGE_CYCLES = 3;

	typedef enum logic [3:0] {
		CMD_INHIBIT = 4'h8,
		CMD_LOAD_MODE = 4'h0,
		CMD_AUTO_REFRESH = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_ACTIVATE = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_READ = 4'h5,
		CMD_BURST_STOP = 4'h6,
		CMD_NOP = 4'h7
	} cmd_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_PRE_PDOWN = 3'h1,
		ST_ACT_PDOWN = 3'h2,
		ST_SUSPEND = 3'h3,
		ST_SELF_REF = 3'h4,
		ST_DEEP_PDOWN = 3'h5
	} power_state_t;

	typedef struct packed {
		logic chip_select_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_strobe_n;
		logic [BANK_BITS-1:0] bank_select;
		logic [ROW_BITS-1:0] row_column_addr;
	} cmd_bus_t;

	typedef struct packed {
		logic high_byte_mask;
		logic low_byte_mask;
	} byte_mask_t;

	function automatic logic [7:0] burst_len_cycles(input logic [2:0] code);
		unique case (code)
			3'h0: burst_len_cycles = 8'h01;
			3'h1: burst_len_cycles = 8'h02;
			3'h2: burst_len_cycles = 8'h04;
			default: burst_len_cycles = 8'h08;
		endcase
	endfunction : burst_len_cycles
endpackage : sdram_cmd_pkg

/* sdram_in_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdram_in_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	input wire logic [WIDTH-1:0] reset_val_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic seeded_ff;

	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end

	// Reset takes a constant; idle value is loaded once after release
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
			seeded_ff <= 1'b0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= seeded_ff ? meta_ff : reset_val_i;
			seeded_ff <= 1'b1;
		end
	end

	// Idle value shown until the second edge after reset, so no false command
	assign sync_o = seeded_ff ? sync_ff : reset_val_i;
endmodule : sdram_in_sync

/* sdram_bank_array.sv */
// Storage for all banks with per-byte write enables
`timescale 1ns/1ps
module sdram_bank_array
	import sdram_cmd_pkg::*;
#(
	parameter int ADDR_BITS = 8,
	parameter int WORD_BITS = 16
) (
	input wire logic core_clk_i,
	input wire logic clk_en_i,
	input wire logic wr_en_i,
	input wire logic [1:0] wr_byte_en_i,
	input wire logic [ADDR_BITS-1:0] addr_i,
	input wire logic [WORD_BITS-1:0] wr_data_i,
	output logic [WORD_BITS-1:0] rd_data_o
);
	logic [WORD_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];
	logic [WORD_BITS-1:0] rd_ff;

	initial begin
		if (WORD_BITS != 16) $error("WORD_BITS must be 16");
	end

	always_ff @(posedge core_clk_i) begin
		if (clk_en_i && wr_en_i && wr_byte_en_i[0]) begin
			mem[addr_i][7:0] <= wr_data_i[7:0];
		end
		if (clk_en_i && wr_en_i && wr_byte_en_i[1]) begin
			mem[addr_i][15:8] <= wr_data_i[15:8];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (clk_en_i) begin
			rd_ff <= mem[addr_i];
		end
	end

	assign rd_data_o = rd_ff;
endmodule : sdram_bank_array

/* sdram_command_interface.sv */
// Command decode, power states, bursts and data path of the SDRAM device
`timescale 1ns/1ps
// Overview of operation
// - Inputs sampled on rising clock edge only
// - Every active edge advances burst and outputs
// - Clock gating enable high processes edges
// - Gating low picks state from bank status
// - Gating enable async during power-down spans
// - Input buffers off in power-down, self refresh
// - Chip select high masks every command
// - Command from select and three strobes
// - Write mask high blocks that byte
// - Read mask high floats byte two later
// - Low mask bits 0-7, high 8-15
// - Banks 4096 rows, 256 columns, 16 bits
// - Activate takes bank and row address
// - Column command address gives burst start
// - Bursts 1,2,4,8 with early terminate
// - Auto precharge starts after burst ends
// - New column address accepted each cycle
// - Precharge one bank while accessing another
// - Temperature sensor default on, refresh programmable
// - Column from bits 0-7, bit 10 autoprecharge
// - Precharge bit 10 high means all banks
// - Load mode bank select picks register
module sdram_command_interface
	import sdram_cmd_pkg::*;
#(
	parameter int SIM_ROW_BITS = 2
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic clock_gate_en_i,
	input wire cmd_bus_t cmd_i,
	input wire byte_mask_t mask_i,
	input wire logic [DATA_BITS-1:0] data_lines_i,
	output logic [DATA_BITS-1:0] data_lines_o,
	output logic [1:0] data_lines_oe_o,
	output logic [NUM_BANKS-1:0] bank_open_o,
	output power_state_t power_state_o,
	output logic input_buffers_on_o,
	output logic [PART_REF_BITS-1:0] partial_array_refresh_o,
	output logic temp_compensated_refresh_o
);
	localparam int PIN_BITS = $bits(cmd_bus_t) + $bits(byte_mask_t) + DATA_BITS;
	localparam int ARR_ADDR = BANK_BITS + SIM_ROW_BITS + COL_BITS;
	localparam logic [PIN_BITS-1:0] PIN_IDLE = {1'b1, 3'h7, {(PIN_BITS-4){1'b0}}};

	logic [PIN_BITS-1:0] pins_sync;
	logic cke_sync;
	cmd_bus_t cmd_s;
	byte_mask_t mask_s;
	logic [DATA_BITS-1:0] din_s;
	cmd_t cmd;
	logic [3:0] cmd_code;
	logic edge_on;
	logic cke_prev_ff;
	power_state_t state_ff;
	power_state_t nxt_state;
	logic [NUM_BANKS-1:0] open_ff;
	logic [ROW_BITS-1:0] row_ff [NUM_BANKS];
	logic [1:0] pre_cnt_ff [NUM_BANKS];
	logic [11:0] mode_ff;
	logic [11:0] ext_mode_ff;
	logic burst_on_ff;
	logic burst_wr_ff;
	logic burst_ap_ff;
	logic [7:0] burst_cnt_ff;
	logic [BANK_BITS-1:0] burst_bank_ff;
	logic [COL_BITS-1:0] burst_col_ff;
	logic [MASK_LATENCY-1:0] lo_mask_pipe_ff;
	logic [MASK_LATENCY-1:0] hi_mask_pipe_ff;
	logic rd_valid_ff;
	logic [DATA_BITS-1:0] arr_rd;
	logic [DATA_BITS-1:0] dout_ff;
	logic [1:0] oe_ff;
	logic col_cmd;
	logic burst_end;
	logic [COL_BITS-1:0] cur_col;
	logic [BANK_BITS-1:0] cur_bank;
	logic [ARR_ADDR-1:0] arr_addr;
	logic arr_wr;

	initial begin
		if (SIM_ROW_BITS < 1 || SIM_ROW_BITS > ROW_BITS) $error("SIM_ROW_BITS out of range");
	end

	// Pin capture through two flops, rising edge only
	sdram_in_sync #(.WIDTH(PIN_BITS)) u_pin_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.async_i({cmd_i, mask_i, data_lines_i}),
		.reset_val_i(PIN_IDLE),
		.sync_o(pins_sync)
	);

	// Gating enable is always synchronised, so it is usable async in power-down
	sdram_in_sync #(.WIDTH(1)) u_cke_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.async_i(clock_gate_en_i),
		.reset_val_i(1'b1),
		.sync_o(cke_sync)
	);

	assign {cmd_s, mask_s, din_s} = pins_sync;

	// Gate internal clocking; power-down wakes on the enable alone
	assign edge_on = clk_en_i && cke_sync && cke_prev_ff;

	// Deselect masks everything; else select plus strobes
	assign cmd_code = {cmd_s.chip_select_n, cmd_s.row_strobe_n, cmd_s.col_strobe_n,
		cmd_s.write_strobe_n};
	assign cmd = cmd_s.chip_select_n ? CMD_INHIBIT : cmd_t'(cmd_code);

	assign col_cmd = edge_on && (cmd == CMD_READ || cmd == CMD_WRITE);
	assign burst_end = burst_on_ff && (burst_cnt_ff == 8'h01);
	assign cur_col = col_cmd ? cmd_s.row_column_addr[COL_BITS-1:0] : burst_col_ff;
	assign cur_bank = col_cmd ? cmd_s.bank_select : burst_bank_ff;
	assign arr_addr = {cur_bank, row_ff[cur_bank][SIM_ROW_BITS-1:0], cur_col};
	assign arr_wr = (col_cmd && cmd == CMD_WRITE) || (burst_on_ff && burst_wr_ff && !col_cmd);

	sdram_bank_array #(.ADDR_BITS(ARR_ADDR), .WORD_BITS(DATA_BITS)) u_array (
		.core_clk_i(core_clk_i),
		.clk_en_i(edge_on),
		.wr_en_i(arr_wr),
		.wr_byte_en_i({~mask_s.high_byte_mask, ~mask_s.low_byte_mask}),
		.addr_i(arr_addr),
		.wr_data_i(din_s),
		.rd_data_o(arr_rd)
	);

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cke_prev_ff <= 1'b1;
		end else if (clk_en_i) begin
			cke_prev_ff <= cke_sync;
		end
	end

	// Power state chosen from bank activity when gating drops
	always_comb begin
		nxt_state = state_ff;
		if (!cke_sync) begin
			if (state_ff == ST_RUN) begin
				if (burst_on_ff) begin
					nxt_state = ST_SUSPEND;
				end else if (open_ff != '0) begin
					nxt_state = ST_ACT_PDOWN;
				end else if (cmd == CMD_AUTO_REFRESH) begin
					nxt_state = ST_SELF_REF;
				end else if (cmd == CMD_BURST_STOP) begin
					nxt_state = ST_DEEP_PDOWN;
				end else begin
					nxt_state = ST_PRE_PDOWN;
				end
			end
		end else begin
			nxt_state = ST_RUN;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= ST_RUN;
		end else if (clk_en_i) begin
			state_ff <= nxt_state;
		end
	end

	// Bank open state, activation and precharge
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			open_ff <= '0;
			for (int b = 0; b < NUM_BANKS; b++) begin
				row_ff[b] <= '0;
				pre_cnt_ff[b] <= 2'h0;
			end
		end else if (edge_on) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				// Self-timed precharge runs per bank, independent of others
				if (pre_cnt_ff[b] != 2'h0) begin
					pre_cnt_ff[b] <= pre_cnt_ff[b] - 2'h1;
					if (pre_cnt_ff[b] == 2'h1) begin
						open_ff[b] <= 1'b0;
					end
				end
			end
			if (burst_end && burst_ap_ff && !col_cmd) begin
				pre_cnt_ff[burst_bank_ff] <= 2'(PRECHARGE_CYCLES);
			end
			// Single-beat burst is complete at once, so precharge starts now
			if (col_cmd && cmd_s.row_column_addr[AP_BIT_POS] &&
				burst_len_cycles(mode_ff[BL_LSB +: 3]) == 8'h01) begin
				pre_cnt_ff[cmd_s.bank_select] <= 2'(PRECHARGE_CYCLES);
			end
			if (cmd == CMD_ACTIVATE) begin
				open_ff[cmd_s.bank_select] <= 1'b1;
				row_ff[cmd_s.bank_select] <= cmd_s.row_column_addr;
			end
			if (cmd == CMD_PRECHARGE) begin
				if (cmd_s.row_column_addr[AP_BIT_POS]) begin
					open_ff <= '0;
				end else begin
					open_ff[cmd_s.bank_select] <= 1'b0;
				end
			end
		end
	end

	// Mode registers
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_ff <= MODE_RESET;
			ext_mode_ff <= EXT_MODE_RESET;
		end else if (edge_on && cmd == CMD_LOAD_MODE) begin
			if (cmd_s.bank_select[1]) begin
				ext_mode_ff <= cmd_s.row_column_addr;
			end else begin
				mode_ff <= cmd_s.row_column_addr;
			end
		end
	end

	// Burst counter; a new column command restarts it
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			burst_on_ff <= 1'b0;
			burst_wr_ff <= 1'b0;
			burst_ap_ff <= 1'b0;
			burst_cnt_ff <= BURST_CNT_RESET;
			burst_bank_ff <= '0;
			burst_col_ff <= '0;
		end else if (edge_on) begin
			if (col_cmd) begin
				burst_on_ff <= (burst_len_cycles(mode_ff[BL_LSB +: 3]) != 8'h01);
				burst_wr_ff <= (cmd == CMD_WRITE);
				burst_ap_ff <= cmd_s.row_column_addr[AP_BIT_POS];
				burst_cnt_ff <= burst_len_cycles(mode_ff[BL_LSB +: 3]) - 8'h01;
				burst_bank_ff <= cmd_s.bank_select;
				burst_col_ff <= cmd_s.row_column_addr[COL_BITS-1:0] + 8'h01;
			end else if (cmd == CMD_BURST_STOP || burst_end) begin
				burst_on_ff <= 1'b0;
				burst_cnt_ff <= BURST_CNT_RESET;
			end else if (burst_on_ff) begin
				burst_cnt_ff <= burst_cnt_ff - 8'h01;
				burst_col_ff <= burst_col_ff + 8'h01;
			end
		end
	end

	// Read pipeline and mask latency pipe
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_valid_ff <= 1'b0;
			lo_mask_pipe_ff <= '0;
			hi_mask_pipe_ff <= '0;
		end else if (edge_on) begin
			rd_valid_ff <= (col_cmd && cmd == CMD_READ) || (burst_on_ff && !burst_wr_ff &&
				!col_cmd && cmd != CMD_BURST_STOP);
			lo_mask_pipe_ff <= {lo_mask_pipe_ff[0], mask_s.low_byte_mask};
			hi_mask_pipe_ff <= {hi_mask_pipe_ff[0], mask_s.high_byte_mask};
		end
	end

	// Output registers
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			dout_ff <= '0;
			oe_ff <= 2'h0;
		end else if (edge_on) begin
			dout_ff <= arr_rd;
			// Mask sampled two edges back governs this word
			oe_ff[0] <= rd_valid_ff && !lo_mask_pipe_ff[MASK_LATENCY-1];
			oe_ff[1] <= rd_valid_ff && !hi_mask_pipe_ff[MASK_LATENCY-1];
		end
	end

	// Status outputs
	logic buf_on_ff;
	logic [PART_REF_BITS-1:0] part_ref_ff;
	logic temp_ref_ff;
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			buf_on_ff <= 1'b1;
			part_ref_ff <= '0;
			temp_ref_ff <= 1'b1;
		end else if (clk_en_i) begin
			buf_on_ff <= !(nxt_state == ST_PRE_PDOWN || nxt_state == ST_ACT_PDOWN ||
				nxt_state == ST_SELF_REF || nxt_state == ST_DEEP_PDOWN);
			part_ref_ff <= ext_mode_ff[PART_REF_LSB +: PART_REF_BITS];
			temp_ref_ff <= !ext_mode_ff[TEMP_REF_LSB];
		end
	end

	assign data_lines_o = dout_ff;
	assign data_lines_oe_o = oe_ff;
	assign bank_open_o = open_ff;
	assign power_state_o = state_ff;
	assign input_buffers_on_o = buf_on_ff;
	assign partial_array_refresh_o = part_ref_ff;
	assign temp_compensated_refresh_o = temp_ref_ff;

	a_deselect_masks: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(edge_on && cmd_s.chip_select_n) |=> ((open_ff & ~$past(open_ff)) == '0) &&
		$stable(mode_ff) && $stable(ext_mode_ff));
	a_activate_opens: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(edge_on && cmd == CMD_ACTIVATE) |=> open_ff[$past(cmd_s.bank_select)]);
	a_prech_all: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(edge_on && cmd == CMD_PRECHARGE && cmd_s.row_column_addr[AP_BIT_POS] &&
		cmd != CMD_ACTIVATE) |=> open_ff == '0);
	a_gate_freeze: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && !cke_sync) |=> $stable(burst_cnt_ff) && $stable(dout_ff));
	a_suspend_entry: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && !cke_sync && state_ff == ST_RUN && burst_on_ff) |=>
		state_ff == ST_SUSPEND);
	a_buffers_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && state_ff == ST_PRE_PDOWN && !cke_sync) |-> !input_buffers_on_o);
	a_mask_float: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(edge_on && mask_s.low_byte_mask) ##1 edge_on[*2] |=> !data_lines_oe_o[0]);
	a_burst_count: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(edge_on && burst_on_ff && !col_cmd && cmd != CMD_BURST_STOP && !burst_end) |=>
		burst_cnt_ff == $past(burst_cnt_ff) - 8'h01);
	a_burst_stop: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(edge_on && cmd == CMD_BURST_STOP) |=> !burst_on_ff);
	a_wr_mask: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(arr_wr && mask_s.high_byte_mask) |-> !u_array.wr_byte_en_i[1]);
endmodule : sdram_command_interface

/* sdram_host_model.sv */
// Host memory controller model driving command, mask, data and clock gating pins
`timescale 1ns/1ps
module sdram_host_model
	import sdram_cmd_pkg::*;
(
	input wire logic core_clk_i,
	output cmd_bus_t cmd_o,
	output byte_mask_t mask_o,
	output logic [DATA_BITS-1:0] data_o,
	output logic gate_o
);
	initial begin
		cmd_o = {CMD_NOP, 2'h0, 12'h000};
		mask_o = '0;
		data_o = 16'h0000;
		gate_o = 1'b1;
	end

	// Caller activates a row before any column command to that bank
	task automatic issue(input cmd_t c, input logic [1:0] ba, input logic [11:0] a,
		input byte_mask_t m, input logic [15:0] d);
		@(posedge core_clk_i);
		#1;
		cmd_o = {c, ba, a};
		mask_o = m;
		data_o = d;
	endtask : issue

	// Idle cycle; released data lines show the inverted last value
	task automatic nop();
		@(posedge core_clk_i);
		#1;
		cmd_o = {CMD_NOP, 2'h0, 12'h000};
		mask_o = '0;
		data_o = ~data_o;
	endtask : nop

	task automatic set_gate(input logic g);
		@(posedge core_clk_i);
		#1;
		gate_o = g;
	endtask : set_gate
endmodule : sdram_host_model

/* sdram_command_interface_test.sv */
// Self-checking testbench for the SDRAM command interface
`timescale 1ns/1ps
module sdram_command_interface_test;
	import sdram_cmd_pkg::*;
	localparam int SROW = 2;
	logic core_clk_i;
	logic reset_i;
	cmd_bus_t cmd;
	byte_mask_t mask;
	logic [15:0] din;
	logic [15:0] dout;
	logic [1:0] oe;
	logic [3:0] bank_open;
	power_state_t pst;
	logic buf_on;
	logic [2:0] part_ref;
	logic temp_ref;
	logic gate;
	int n_errors = 0;
	int comparisons = 0;
	logic [15:0] lfsr = 16'hC725;
	logic [15:0] mem [int];
	int open_row [4];
	logic [3:0] exp_open = 4'h0;

	sdram_host_model host (.core_clk_i(core_clk_i), .cmd_o(cmd), .mask_o(mask),
		.data_o(din), .gate_o(gate));

	sdram_command_interface #(.SIM_ROW_BITS(SROW)) dut (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .clk_en_i(1'b1), .clock_gate_en_i(gate), .cmd_i(cmd),
		.mask_i(mask), .data_lines_i(din), .data_lines_o(dout), .data_lines_oe_o(oe),
		.bank_open_o(bank_open), .power_state_o(pst), .input_buffers_on_o(buf_on),
		.partial_array_refresh_o(part_ref), .temp_compensated_refresh_o(temp_ref));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	function automatic logic [15:0] next_rand();
		lfsr = lfsr[0] ? ((lfsr >> 1) ^ 16'hB400) : (lfsr >> 1);
		return lfsr;
	endfunction : next_rand

	function automatic int key(input int b, input int c);
		return (b * 4 + open_row[b]) * 256 + c;
	endfunction : key

	task automatic print_verdict();
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_state(input power_state_t got, input power_state_t exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: state %s expected %s", $time, got.name(), exp.name());
		end
	endtask : check_state

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : wait_cyc

	task automatic wait_state(input logic run);
		for (int k = 0; k < 20 && ((pst === ST_RUN) != run); k++)
			wait_cyc(1);
	endtask : wait_state

	task automatic act(input int b);
		open_row[b] = int'(next_rand()) % (1 << SROW);
		exp_open[b] = 1'b1;
		host.issue(CMD_ACTIVATE, 2'(b), 12'(open_row[b]), '0, 16'h0000);
		host.nop();
	endtask : act

	task automatic wr(input int b, input int c, input byte_mask_t m, input logic [15:0] d);
		int k;
		k = key(b, c);
		host.issue(CMD_WRITE, 2'(b), 12'(c), m, d);
		host.nop();
		if (!mem.exists(k))
			mem[k] = 16'h0000;
		if (!m.low_byte_mask)
			mem[k][7:0] = d[7:0];
		if (!m.high_byte_mask)
			mem[k][15:8] = d[15:8];
	endtask : wr

	task automatic rd(input int b, input int c, input byte_mask_t m, input logic ap);
		// Read mask leads its word by two edges, so it goes out a cycle early
		host.issue(CMD_NOP, 2'h0, 12'h000, m, 16'h0000);
		host.issue(CMD_READ, 2'(b), {1'b0, ap, 2'h0, 8'(c)}, m, 16'h0000);
		host.nop();
		wait_cyc(3);
	endtask : rd

	task automatic gate_off(input cmd_t c, input int b);
		host.issue(c, 2'(b), 12'h000, '0, 16'h0000);
		host.set_gate(1'b0);
		host.nop();
		wait_state(1'b0);
	endtask : gate_off

	task automatic gate_on();
		host.set_gate(1'b1);
		wait_state(1'b1);
		wait_cyc(2);
	endtask : gate_on

	task automatic check_word(input int b, input int c, input byte_mask_t m);
		logic [15:0] keep;
		keep = {{8{~m.high_byte_mask}}, {8{~m.low_byte_mask}}};
		check_val({14'h0000, oe}, {14'h0000, ~m.high_byte_mask, ~m.low_byte_mask});
		check_val(dout & keep, mem[key(b, c)] & keep);
	endtask : check_word

	task automatic check_banks();
		check_val({12'h000, bank_open}, {12'h000, exp_open});
	endtask : check_banks

	initial begin
		#20000;
		n_errors++;
		print_verdict();
	end

	initial begin
		logic [11:0] a;
		int cols [3];
		cols = '{19, 16, 18};
		reset_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		#1;
		reset_i = 1'b0;
		check_val({5'h00, oe, bank_open, buf_on, part_ref, temp_ref}, 16'h0011);
		check_state(pst, ST_RUN);
		for (int i = 0; i < 2; i++) begin
			a = i ? 12'h00D : 12'h002;
			host.issue(CMD_LOAD_MODE, 2'h2, a, '0, 16'h0000);
			host.nop();
			wait_cyc(4);
			check_val({12'h000, part_ref, temp_ref}, {12'h000, a[2:0], ~a[3]});
		end
		act(0);
		act(2);
		// Activate pattern with chip select high
		host.issue(cmd_t'(4'hB), 2'h3, 12'h001, '0, 16'h0000);
		host.nop();
		wait_cyc(3);
		check_banks();
		for (int i = 0; i < 4; i++) begin
			wr(0, 8 + i, '0, next_rand());
			wr(0, 8 + i, byte_mask_t'(2'(i)), next_rand());
		end
		for (int i = 0; i < 4; i++) begin
			rd(0, 8 + i, byte_mask_t'(2'(i)), 1'b0);
			check_word(0, 8 + i, byte_mask_t'(2'(i)));
		end
		for (int i = 16; i < 20; i++)
			wr(2, i, '0, next_rand());
		for (int i = 0; i < 3; i++)
			host.issue(CMD_READ, 2'h2, 12'(cols[i]), '0, 16'h0000);
		host.nop();
		for (int i = 0; i < 3; i++) begin
			wait_cyc(1);
			check_word(2, cols[i], '0);
		end
		host.issue(CMD_PRECHARGE, 2'h0, 12'h000, '0, 16'h0000);
		host.nop();
		wait_cyc(3);
		exp_open[0] = 1'b0;
		check_banks();
		host.issue(CMD_LOAD_MODE, 2'h0, 12'h002, '0, 16'h0000);
		host.nop();
		wait_cyc(4);
		check_val({12'h000, part_ref, temp_ref}, 16'h000A);
		rd(2, 16, '0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			check_word(2, 16 + i, '0);
			wait_cyc(1);
		end
		check_val({14'h0000, oe}, 16'h0000);
		host.issue(CMD_LOAD_MODE, 2'h0, 12'h000, '0, 16'h0000);
		host.nop();
		wait_cyc(4);
		rd(2, 17, '0, 1'b1);
		check_word(2, 17, '0);
		wait_cyc(8);
		exp_open[2] = 1'b0;
		check_banks();
		host.set_gate(1'b0);
		wait_state(1'b0);
		check_state(pst, ST_PRE_PDOWN);
		check_val({15'h0000, buf_on}, 16'h0000);
		host.set_gate(1'b1);
		wait_state(1'b1);
		check_state(pst, ST_RUN);
		check_val({15'h0000, buf_on}, 16'h0001);
		wait_cyc(2);
		act(1);
		wait_cyc(3);
		check_banks();
		for (int i = 0; i < 8; i++)
			wr(1, i, '0, next_rand());
		host.set_gate(1'b0);
		wait_state(1'b0);
		check_state(pst, ST_ACT_PDOWN);
		host.set_gate(1'b1);
		wait_state(1'b1);
		wait_cyc(2);
		host.issue(CMD_LOAD_MODE, 2'h0, 12'h003, '0, 16'h0000);
		host.nop();
		wait_cyc(4);
		gate_off(CMD_READ, 1);
		check_state(pst, ST_SUSPEND);
		check_val({15'h0000, buf_on}, 16'h0001);
		gate_on();
		wait_cyc(10);
		host.issue(CMD_PRECHARGE, 2'h1, 12'h400, '0, 16'h0000);
		host.nop();
		wait_cyc(3);
		exp_open = 4'h0;
		check_banks();
		gate_off(CMD_AUTO_REFRESH, 0);
		check_state(pst, ST_SELF_REF);
		check_val({15'h0000, buf_on}, 16'h0000);
		gate_on();
		check_state(pst, ST_RUN);
		gate_off(CMD_BURST_STOP, 0);
		check_state(pst, ST_DEEP_PDOWN);
		check_val({15'h0000, buf_on}, 16'h0000);
		gate_on();
		check_state(pst, ST_RUN);
		print_verdict();
	end
endmodule : sdram_command_interface_test
